// *** hw/rsw_consts.svh ***
`ifndef RSW_CONSTS_SVH
`define RSW_CONSTS_SVH

// Timing
`define RSW_CLK_MHZ    100
`define RSW_T_FIL_NS   200
`define RSW_FIL_CYC    ((`RSW_T_FIL_NS * `RSW_CLK_MHZ + 999) / 1000)
`define RSW_T_ACTV_US  20
`define RSW_ACTV_CYC   (`RSW_T_ACTV_US * `RSW_CLK_MHZ)

// Register byte offsets
`define RSW_OFF_KEY    8'h00
`define RSW_OFF_RELOAD 8'h04
`define RSW_OFF_COUNT  8'h08
`define RSW_OFF_STATUS 8'h0c
`define RSW_OFF_MODE   8'h10
`define RSW_OFF_BWAIT  8'h14

// Values and fields
`define RSW_KEY_LOCK   8'h55
`define RSW_BOOT_VEC   16'h0000
`define RSW_MC_BASE    3'h4
`define RSW_BW_RST     2'h2
`define RSW_SYNC_RST   3'h1
`define RSW_CNT_ONES   24'hffffff
`define RSW_ST_PWR     0
`define RSW_ST_EN      1
`define RSW_PC_IDLE    0
`define RSW_PC_PD      1
`endif

// *** hw/rsw_pkg.sv ***
`default_nettype none
package rsw_pkg;
  typedef logic [23:0] rsw_cnt_t;
  typedef logic [7:0]  rsw_fcnt_t;
  typedef logic [11:0] rsw_hcnt_t;
  typedef enum logic [1:0] {
    RS_RUN    = 2'b00,
    RS_ASSERT = 2'b01,
    RS_HOLD   = 2'b10
  } rsw_rst_st_t;
endpackage
`default_nettype wire

// *** hw/rsw_wd_if.sv ***
`default_nettype none
interface rsw_wd_if;
  logic       clear;
  logic       en;
  logic       tick;
  logic       load;
  logic [7:0] load_val;
  logic [23:0] count;
  logic       ovf;
  modport ctrl (output clear, en, tick, load, load_val,
                input count, ovf);
  modport wdog (input clear, en, tick, load, load_val,
                output count, ovf);
endinterface
`default_nettype wire

// *** hw/rsw_wdog.sv ***
`include "rsw_consts.svh"
`default_nettype none
module rsw_wdog
  import rsw_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control and counter
  rsw_wd_if.wdog    wd
);

  rsw_cnt_t next_count;
  logic     next_ovf;

  // Counter next value: clear, reload, count
  always_comb begin
    next_count = wd.count;
    next_ovf   = 1'b0;
    if (wd.clear) begin
      next_count = '0;
    end else if (wd.load) begin
      next_count = {wd.load_val, 16'h0000};
    end else if (wd.en && wd.tick) begin
      next_count = wd.count + 24'h000001;
      next_ovf   = (wd.count == `RSW_CNT_ONES);
    end
  end

  // Counter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd.count <= '0;
      wd.ovf   <= 1'b0;
    end else begin
      wd.count <= next_count;
      wd.ovf   <= next_ovf;
    end
  end

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    wd.load && !wd.clear |=> wd.count == {$past(wd.load_val), 16'h0000};
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload did not set counter");

  property p_inc;
    @(posedge pclk) disable iff (!presetn)
    wd.en && wd.tick && !wd.load && !wd.clear
      |=> wd.count == $past(wd.count) + 24'h000001;
  endproperty
  a_inc: assert property (p_inc)
    else $error("counter did not add one");

  property p_idle;
    @(posedge pclk) disable iff (!presetn)
    !wd.en && !wd.load && !wd.clear |=> $stable(wd.count) && !wd.ovf;
  endproperty
  a_idle: assert property (p_idle)
    else $error("disabled counter moved");

  property p_ovf;
    @(posedge pclk) disable iff (!presetn)
    wd.en && wd.tick && !wd.load && !wd.clear
      && wd.count == `RSW_CNT_ONES |=> wd.ovf && wd.count == '0;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow missed");

  property p_clr;
    @(posedge pclk) disable iff (!presetn)
    wd.clear |=> wd.count == '0 && !wd.ovf;
  endproperty
  a_clr: assert property (p_clr)
    else $error("counter not zero after reset");

endmodule // rsw_wdog
`default_nettype wire

// *** hw/rsw_top.sv ***
`include "rsw_consts.svh"
`default_nettype none
module rsw_top
  import rsw_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources from pins
  input  wire logic        reset_in_n,
  input  wire logic        low_supply_detect,
  input  wire logic        dbg_reset_req,
  // Core status
  input  wire logic        mem_xfer,
  input  wire logic        prefetch_stall,
  // Reset and mode outputs
  output logic             core_reset,
  output logic             plm_reset_n,
  output logic [15:0]      boot_addr,
  output logic             boot_start,
  output logic             idle_mode,
  output logic             pdown_mode
);

  rsw_wd_if wd ();

  // Valid register offset
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `RSW_OFF_KEY) || (a == `RSW_OFF_RELOAD) ||
              (a == `RSW_OFF_COUNT) || (a == `RSW_OFF_STATUS) ||
              (a == `RSW_OFF_MODE) || (a == `RSW_OFF_BWAIT);
  endfunction

  // Consecutive-cycle filter step
  function automatic rsw_fcnt_t filt_next(input logic hit,
                                          input rsw_fcnt_t c);
    if (!hit) begin
      filt_next = '0;
    end else if (c == 8'(`RSW_FIL_CYC)) begin
      filt_next = c;
    end else begin
      filt_next = c + 8'h01;
    end
  endfunction

  // Two-stage synchronisers for the pins
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= `RSW_SYNC_RST;
      sync_b <= `RSW_SYNC_RST;
    end else begin
      sync_a <= {dbg_reset_req, low_supply_detect, reset_in_n};
      sync_b <= sync_a;
    end
  end

  logic pin_low;
  logic sag_low;
  logic dbg_s;
  assign pin_low = !sync_b[0];
  assign sag_low = sync_b[1];
  assign dbg_s   = sync_b[2];

  // Spike filters for pin and supply monitor
  rsw_fcnt_t ext_cnt;
  rsw_fcnt_t sag_cnt;
  rsw_fcnt_t next_ext_cnt;
  rsw_fcnt_t next_sag_cnt;
  logic      ext_act;
  logic      sag_act;
  logic      next_ext_act;
  logic      next_sag_act;
  always_comb begin
    next_ext_cnt = filt_next(pin_low, ext_cnt);
    next_sag_cnt = filt_next(sag_low, sag_cnt);
    next_ext_act = (next_ext_cnt == 8'(`RSW_FIL_CYC));
    next_sag_act = (next_sag_cnt == 8'(`RSW_FIL_CYC));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt <= '0;
      sag_cnt <= '0;
      ext_act <= 1'b0;
      sag_act <= 1'b0;
    end else begin
      ext_cnt <= next_ext_cnt;
      sag_cnt <= next_sag_cnt;
      ext_act <= next_ext_act;
      sag_act <= next_sag_act;
    end
  end

  // Reset sequencer
  rsw_rst_st_t st;
  rsw_rst_st_t next_st;
  rsw_hcnt_t   hold_cnt;
  rsw_hcnt_t   next_hold_cnt;
  logic        sag_seen;
  logic        next_sag_seen;
  logic        next_core_reset;
  logic        next_boot_start;
  logic        src;
  assign src = ext_act || sag_act || dbg_s || wd.ovf;

  always_comb begin
    next_st       = st;
    next_hold_cnt = hold_cnt;
    next_sag_seen = sag_seen;
    case (st)
      RS_RUN: begin
        if (src) begin
          next_st       = RS_ASSERT;
          next_sag_seen = sag_act;
        end
      end
      RS_ASSERT: begin
        next_sag_seen = sag_seen || sag_act;
        if (!src) begin
          if (sag_seen) begin
            next_st       = RS_HOLD;
            next_hold_cnt = '0;
          end else begin
            next_st = RS_RUN;
          end
        end
      end
      RS_HOLD: begin
        if (src) begin
          next_st       = RS_ASSERT;
          next_sag_seen = sag_act;
        end else if (hold_cnt == 12'(`RSW_ACTV_CYC - 1)) begin
          next_st = RS_RUN;
        end else begin
          next_hold_cnt = hold_cnt + 12'h001;
        end
      end
      default: begin
        next_st = RS_RUN;
      end
    endcase
    next_core_reset = (next_st != RS_RUN);
    next_boot_start = core_reset && !next_core_reset;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= RS_ASSERT;
      hold_cnt    <= '0;
      sag_seen    <= 1'b1;
      core_reset  <= 1'b1;
      plm_reset_n <= 1'b0;
      boot_start  <= 1'b0;
      boot_addr   <= `RSW_BOOT_VEC;
    end else begin
      st          <= next_st;
      hold_cnt    <= next_hold_cnt;
      sag_seen    <= next_sag_seen;
      core_reset  <= next_core_reset;
      plm_reset_n <= !next_core_reset;
      boot_start  <= next_boot_start;
      boot_addr   <= `RSW_BOOT_VEC;
    end
  end

  // Machine cycle timing
  logic [2:0] mc_cnt;
  logic [2:0] next_mc_cnt;
  logic [2:0] mc_len;
  logic       mc_tick;
  logic       next_mc_tick;
  logic [1:0] bwait;
  logic [2:0] bw_clk;
  always_comb begin
    bw_clk = `RSW_MC_BASE + {1'b0, bwait};
    mc_len = (mem_xfer && bw_clk > `RSW_MC_BASE) ? bw_clk
                                                  : `RSW_MC_BASE;
    next_mc_cnt  = mc_cnt;
    next_mc_tick = 1'b0;
    if (core_reset) begin
      next_mc_cnt = '0;
    end else if (!prefetch_stall) begin
      if (mc_cnt >= mc_len - 3'h1) begin
        next_mc_cnt  = '0;
        next_mc_tick = 1'b1;
      end else begin
        next_mc_cnt = mc_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_cnt  <= '0;
      mc_tick <= 1'b0;
    end else begin
      mc_cnt  <= next_mc_cnt;
      mc_tick <= next_mc_tick;
    end
  end

  // Register file and APB answer
  logic [7:0]  key;
  logic [7:0]  next_key;
  logic [1:0]  mode;
  logic [1:0]  next_mode;
  logic [1:0]  next_bwait;
  logic        pwr_flag;
  logic        next_pwr_flag;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        next_load;
  logic [7:0]  next_load_val;
  logic        next_en;
  logic        wr;
  logic        load_q;
  logic [7:0]  load_val_q;
  logic        en_q;
  assign wr = psel && penable && pready && pwrite && reg_hit(paddr);

  always_comb begin
    next_key      = key;
    next_mode     = mode;
    next_bwait    = bwait;
    next_pwr_flag = pwr_flag;
    next_load     = 1'b0;
    next_load_val = load_val_q;
    if (core_reset || wd.ovf) begin
      next_key   = `RSW_KEY_LOCK;
      next_mode  = '0;
      next_bwait = `RSW_BW_RST;
    end else if (wr) begin
      if (paddr == `RSW_OFF_KEY) begin
        next_key = pwdata[7:0];
      end else if (paddr == `RSW_OFF_RELOAD) begin
        next_load     = 1'b1;
        next_load_val = pwdata[7:0];
      end else if (paddr == `RSW_OFF_MODE) begin
        next_mode = pwdata[1:0];
      end else if (paddr == `RSW_OFF_BWAIT) begin
        next_bwait = pwdata[1:0];
      end
    end
    if (wr && paddr == `RSW_OFF_STATUS && pwdata[`RSW_ST_PWR]) begin
      next_pwr_flag = 1'b0;
    end
    if (sag_act) begin
      next_pwr_flag = 1'b1;
    end
    next_en = (next_key != `RSW_KEY_LOCK)
              && (next_mode == '0);
    // Read and error answer, one wait state
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && !reg_hit(paddr);
    next_prdata  = '0;
    if (next_pready && !pwrite) begin
      if (paddr == `RSW_OFF_KEY) begin
        next_prdata = {24'h000000, key};
      end else if (paddr == `RSW_OFF_RELOAD) begin
        next_prdata = {24'h000000, wd.count[23:16]};
      end else if (paddr == `RSW_OFF_COUNT) begin
        next_prdata = {8'h00, wd.count};
      end else if (paddr == `RSW_OFF_STATUS) begin
        next_prdata[`RSW_ST_PWR] = pwr_flag;
        next_prdata[`RSW_ST_EN]  = en_q;
      end else if (paddr == `RSW_OFF_MODE) begin
        next_prdata = {30'h00000000, mode};
      end else if (paddr == `RSW_OFF_BWAIT) begin
        next_prdata = {30'h00000000, bwait};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key        <= `RSW_KEY_LOCK;
      mode       <= '0;
      bwait      <= `RSW_BW_RST;
      pwr_flag   <= 1'b1;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= '0;
      load_q     <= 1'b0;
      load_val_q <= '0;
      en_q       <= 1'b0;
      idle_mode  <= 1'b0;
      pdown_mode <= 1'b0;
    end else begin
      key        <= next_key;
      mode       <= next_mode;
      bwait      <= next_bwait;
      pwr_flag   <= next_pwr_flag;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      prdata     <= next_prdata;
      load_q     <= next_load;
      load_val_q <= next_load_val;
      en_q       <= next_en;
      idle_mode  <= next_mode[`RSW_PC_IDLE];
      pdown_mode <= next_mode[`RSW_PC_PD];
    end
  end

  // Watchdog hookup
  assign wd.clear    = core_reset;
  assign wd.en       = en_q;
  assign wd.tick     = mc_tick;
  assign wd.load     = load_q;
  assign wd.load_val = load_val_q;

  rsw_wdog u_wdog (
    .pclk    (pclk),
    .presetn (presetn),
    .wd      (wd)
  );

  property p_src;
    @(posedge pclk) disable iff (!presetn)
    ext_act || sag_act || dbg_s || wd.ovf |=> core_reset;
  endproperty
  a_src: assert property (p_src)
    else $error("reset source did not reset core");

  property p_plm;
    @(posedge pclk) disable iff (!presetn)
    core_reset == !plm_reset_n;
  endproperty
  a_plm: assert property (p_plm)
    else $error("logic module reset out of step");

  property p_nostr;
    @(posedge pclk) disable iff (!presetn)
    st == RS_ASSERT && !sag_seen && !src |=> !core_reset;
  endproperty
  a_nostr: assert property (p_nostr)
    else $error("pin reset stretched");

  property p_filt;
    @(posedge pclk) disable iff (!presetn)
    $rose(ext_act) |-> $past(ext_cnt) == 8'(`RSW_FIL_CYC - 1);
  endproperty
  a_filt: assert property (p_filt)
    else $error("pin filter too short");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    st == RS_HOLD && hold_cnt < 12'(`RSW_ACTV_CYC - 1) |=> core_reset;
  endproperty
  a_hold: assert property (p_hold)
    else $error("supply reset released early");

  property p_pwr;
    @(posedge pclk) disable iff (!presetn)
    sag_act |=> pwr_flag;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power-up flag not set");

  property p_dbg;
    @(posedge pclk) disable iff (!presetn)
    dbg_s && mode != '0 |=> core_reset ##1 mode == '0;
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug reset ignored in low power");

  property p_key;
    @(posedge pclk) disable iff (!presetn)
    core_reset |=> key == `RSW_KEY_LOCK ##1 !en_q;
  endproperty
  a_key: assert property (p_key)
    else $error("key not locked by reset");

  property p_low;
    @(posedge pclk) disable iff (!presetn)
    mode != '0 |-> !en_q;
  endproperty
  a_low: assert property (p_low)
    else $error("watchdog enabled in low power");

  property p_boot;
    @(posedge pclk) disable iff (!presetn)
    $fell(core_reset) |-> boot_start && boot_addr == `RSW_BOOT_VEC;
  endproperty
  a_boot: assert property (p_boot)
    else $error("no start at reset vector");

  property p_mc;
    @(posedge pclk) disable iff (!presetn)
    mc_tick |=> !mc_tick [*3];
  endproperty
  a_mc: assert property (p_mc)
    else $error("machine cycle shorter than four clocks");

endmodule // rsw_top
`default_nettype wire

// *** dv/rsw_far_side.sv ***
`default_nettype none
// Far side model: reset switch, supply monitor and debug probe
module rsw_far_side (
  // Clock
  input  wire logic pclk,
  // Reset sources
  output var logic  reset_in_n,
  output var logic  low_supply_detect,
  output var logic  dbg_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels: pin pulled up, supply good, no debug request
  initial begin
    reset_in_n        = 1'b1;
    low_supply_detect = 1'b0;
    dbg_reset_req     = 1'b0;
  end

  // Switch pulls the pin low for n running clocks
  task automatic pin_low(input int n);
    reset_in_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reset_in_n <= 1'b1;
  endtask

  // Supply sags for n clocks, then recovers
  task automatic supply_low(input int n);
    low_supply_detect <= 1'b1;
    repeat (n) @(posedge pclk);
    low_supply_detect <= 1'b0;
  endtask

  // Debug probe requests a reset for n clocks
  task automatic dbg_high(input int n);
    dbg_reset_req <= 1'b1;
    repeat (n) @(posedge pclk);
    dbg_reset_req <= 1'b0;
  endtask
endmodule // rsw_far_side
`default_nettype wire

// *** dv/tb_reset_supervisor_watchdog.sv ***
`include "rsw_consts.svh"
`default_nettype none
module tb_reset_supervisor_watchdog;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, kv, rv;
  logic [31:0] pwdata, prdata, rd, r32;
  logic        reset_in_n, low_supply_detect, dbg_reset_req;
  logic        mem_xfer, prefetch_stall, core_reset, plm_reset_n;
  logic        boot_start, idle_mode, pdown_mode, er, bad;
  logic [15:0] boot_addr;
  int          num_errors, samples_checked, n_boot, n;
  int          seed = 23;
  int          m_key, m_pwr, m_mode, m_bw;
  time         t_acc;

  rsw_top i_rsw_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_in_n(reset_in_n),
    .low_supply_detect(low_supply_detect), .dbg_reset_req(dbg_reset_req),
    .mem_xfer(mem_xfer), .prefetch_stall(prefetch_stall),
    .core_reset(core_reset), .plm_reset_n(plm_reset_n),
    .boot_addr(boot_addr), .boot_start(boot_start),
    .idle_mode(idle_mode), .pdown_mode(pdown_mode));

  rsw_far_side i_rsw_far_side (
    .pclk(pclk), .reset_in_n(reset_in_n),
    .low_supply_detect(low_supply_detect), .dbg_reset_req(dbg_reset_req));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tmo();
    num_errors++;
    $display("ERROR %0t: wait ran out", $time);
    print_verdict();
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
      if (k > 50) tmo();
    end while (pready !== 1'b1);
    rd    = prdata;
    er    = pslverr;
    t_acc = $time;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Wait until core reset shows the given level, n counts the clocks
  task automatic wait_cr(input logic v, input int lim);
    n = 0;
    while (core_reset !== v) begin
      @(posedge pclk);
      n++;
      if (n > lim) tmo();
    end
  endtask

  // Model: what every reset does to the registers
  task automatic model_reset();
    m_key  = 'h55;
    m_mode = 0;
    m_bw   = 2;
  endtask

  // Counter advance over a gap, per clocks per tick (0 = frozen)
  task automatic rate(input int per);
    logic [31:0] c1;
    time         t1;
    int          cyc, ex, d;
    apb(1'b0, `RSW_OFF_COUNT, 32'h0);
    c1 = rd;
    t1 = t_acc;
    repeat (200) @(posedge pclk);
    apb(1'b0, `RSW_OFF_COUNT, 32'h0);
    cyc = int'((t_acc - t1) / 10);
    ex  = (per == 0) ? 0 : cyc / per;
    d   = int'(rd - c1);
    chk(32'(d >= ex - 1 && d <= ex + 1), 32'h1);
    chk(32'($isunknown(rd ^ c1)), 32'h0);
  endtask

  // Logic module reset always mirrors the core reset
  always @(negedge pclk)
    if (presetn) chk(32'(plm_reset_n), 32'(!core_reset));

  // Reset vector offered as the core starts
  always @(posedge pclk) begin
    if (boot_start === 1'b1) begin
      n_boot++;
      chk(32'(boot_addr), 32'h0);
    end
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, mem_xfer, prefetch_stall} = '0;
    paddr  = '0;
    pwdata = '0;
    num_errors = 0;
    samples_checked = 0;
    n_boot = 0;
    m_pwr = 1;
    model_reset();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_cr(1'b0, `RSW_ACTV_CYC + 100);
    chk(32'(n >= `RSW_ACTV_CYC), 32'h1);
    rd_chk(`RSW_OFF_KEY, m_key);
    rd_chk(`RSW_OFF_COUNT, 32'h0);
    rd_chk(`RSW_OFF_STATUS, m_pwr);
    rd_chk(`RSW_OFF_BWAIT, m_bw);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, `RSW_OFF_STATUS, 32'h1);
    m_pwr = 0;
    rd_chk(`RSW_OFF_STATUS, m_pwr);
    rate(0);
    $display("test power_up done");
    // Enable with a random key, reload with a random upper byte
    do begin
      r32 = $random(seed);
      kv  = r32[7:0];
    end while (kv == 8'h55);
    r32 = $random(seed);
    rv  = r32[7:0];
    apb(1'b1, `RSW_OFF_KEY, {24'h0, kv});
    rd_chk(`RSW_OFF_STATUS, 32'h2);
    apb(1'b1, `RSW_OFF_RELOAD, {24'h0, rv});
    rd_chk(`RSW_OFF_RELOAD, {24'h0, rv});
    apb(1'b0, `RSW_OFF_COUNT, 32'h0);
    chk(32'(rd[23:16]), 32'(rv));
    chk(32'(rd[15:0] < 16'h0010), 32'h1);
    rate(4);
    mem_xfer <= 1'b1;
    rate(4 + m_bw);
    apb(1'b1, `RSW_OFF_BWAIT, 32'h0);
    rate(4);
    mem_xfer       <= 1'b0;
    prefetch_stall <= 1'b1;
    rate(0);
    prefetch_stall <= 1'b0;
    apb(1'b1, `RSW_OFF_MODE, 32'h1);
    chk(32'(idle_mode), 32'h1);
    rate(0);
    apb(1'b1, `RSW_OFF_MODE, 32'h2);
    chk(32'(pdown_mode), 32'h1);
    rate(0);
    $display("test watchdog done");
    // Debug reset while powered down
    fork
      i_rsw_far_side.dbg_high(10);
      begin
        repeat (8) @(posedge pclk);
        chk(32'(core_reset), 32'h1);
      end
    join
    wait_cr(1'b0, 8);
    model_reset();
    rd_chk(`RSW_OFF_KEY, m_key);
    rd_chk(`RSW_OFF_MODE, m_mode);
    rd_chk(`RSW_OFF_COUNT, 32'h0);
    $display("test debug done");
    // Short pin pulse is ignored, a long one resets without stretch
    apb(1'b1, `RSW_OFF_KEY, {24'h0, kv});
    bad = 1'b0;
    fork
      i_rsw_far_side.pin_low(`RSW_FIL_CYC / 2);
      repeat (40) begin
        @(posedge pclk);
        if (core_reset !== 1'b0) bad = 1'b1;
      end
    join
    chk(32'(bad), 32'h0);
    fork
      i_rsw_far_side.pin_low(`RSW_FIL_CYC + 30);
      begin
        repeat (`RSW_FIL_CYC + 20) @(posedge pclk);
        chk(32'(core_reset), 32'h1);
      end
    join
    wait_cr(1'b0, 8);
    model_reset();
    rd_chk(`RSW_OFF_KEY, m_key);
    $display("test pin done");
    // Supply sag while powered down
    apb(1'b1, `RSW_OFF_MODE, 32'h2);
    fork
      i_rsw_far_side.supply_low(`RSW_FIL_CYC + 30);
      begin
        repeat (`RSW_FIL_CYC + 20) @(posedge pclk);
        chk(32'(core_reset), 32'h1);
      end
    join
    wait_cr(1'b0, `RSW_ACTV_CYC + 20);
    chk(32'(n >= `RSW_ACTV_CYC), 32'h1);
    m_pwr = 1;
    model_reset();
    rd_chk(`RSW_OFF_STATUS, m_pwr);
    chk(32'(n_boot), 32'h4);
    $display("test supply done");
    print_verdict();
  end
endmodule // tb_reset_supervisor_watchdog
`default_nettype wire
